// file: verilog/cmp_tm2_pkg.sv
/*
  Constants and carrier types for the comparator and timer-two control block.
  Assumes an 8-bit IO register port on a single 50 MHz clock.
*/
package cmp_tm2_pkg;

  // IO addresses
  localparam logic [5:0] ADDR_COMPARATOR_CONTROL = 6'h1A;
  localparam logic [5:0] ADDR_TIMER_TWO_CONTROL = 6'h1C;
  localparam logic [5:0] ADDR_COMPARATOR_SELECTION = 6'h1E;
  localparam logic [5:0] ADDR_INT_EDGE = 6'h0C;
  localparam logic [5:0] ADDR_INT_REQUEST = 6'h05;

  // comparator_control fields
  localparam int CC_ENABLE = 7;
  localparam int CC_RESULT = 6;
  localparam int CC_SAMPLE = 5;
  localparam int CC_INVERT = 4;
  localparam int CC_MINUS_LSB = 1;
  localparam int CC_PLUS = 0;

  // comparator_selection fields
  localparam int CS_PIN_OUT = 7;
  localparam int CS_WAKE = 6;
  localparam int CS_HIGH_RANGE = 5;
  localparam int CS_LOW_RANGE = 4;

  // Edge select and request flag positions
  localparam int EDGE_LSB = 6;
  localparam int REQ_BIT = 4;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_EDGE = 2'h0;

  // Minus input codes
  localparam logic [2:0] MINUS_PIN_THREE = 3'h0;
  localparam logic [2:0] MINUS_PIN_FOUR = 3'h1;
  localparam logic [2:0] MINUS_BANDGAP = 3'h2;
  localparam logic [2:0] MINUS_LADDER = 3'h3;
  localparam logic [2:0] MINUS_PIN_SIX = 3'h4;
  localparam logic [2:0] MINUS_PIN_SEVEN = 3'h5;

  // Timer clock codes
  localparam logic [3:0] TCLK_OFF = 4'h0;
  localparam logic [3:0] TCLK_SYSTEM = 4'h1;
  localparam logic [3:0] TCLK_FAST_RC = 4'h2;
  localparam logic [3:0] TCLK_SLOW_RC = 4'h4;
  localparam logic [3:0] TCLK_COMPARATOR = 4'h5;
  localparam logic [3:0] TCLK_PIN0_RISE = 4'h8;
  localparam logic [3:0] TCLK_PIN0_FALL = 4'h9;
  localparam logic [3:0] TCLK_PIN4_RISE = 4'hC;
  localparam logic [3:0] TCLK_PIN4_FALL = 4'hD;

  // Timer output routes and edge codes
  localparam logic [1:0] TOUT_PIN_THREE = 2'h2;
  localparam logic [1:0] TOUT_PIN_FOUR = 2'h3;
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  typedef struct packed {
    logic write;
    logic read;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_s;

  // Analog front-end settings that leave the block
  typedef struct packed {
    logic enable;
    logic [2:0] minus_sel;
    logic plus_sel;
    logic high_range;
    logic low_range;
    logic [3:0] ladder_level;
  } analog_cfg_s;

  typedef struct packed {
    logic [3:0] clock_sel;
    logic [1:0] out_sel;
    logic pwm_mode;
    logic invert;
  } timer_cfg_s;

endpackage

// file: verilog/edge_sync.sv
/*
  Two-flop synchroniser with rising and falling edge pulses.
  Assumes the input is asynchronous to clock_in.
*/
`timescale 1ns/1ps
module edge_sync
  import cmp_tm2_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  typedef struct packed {
    logic first;
    logic second;
    logic third;
  } sync_state_s;

  sync_state_s state;
  sync_state_s next_state;

  always_comb begin
    next_state = state;
    next_state.first = async_in;
    next_state.second = state.first;
    next_state.third = state.second;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_out = state.second;
  assign rise_out = state.second & ~state.third;
  assign fall_out = ~state.second & state.third;

endmodule // edge_sync

// file: verilog/cmp_tm2_ctrl.sv
/*
  Comparator and timer-two control registers, result conditioning, timer clock
  selection, pin routing, wake-up and comparator interrupt request flag.
  Assumes the core IO port is synchronous to clock_in; analog result, RC clocks
  and pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: Software should disable digital input buffers on pins used by comparator.
// R2: Read-only result bit: 1 when plus above minus, else 0.
// R3: Sample bit chooses raw result or result registered on timer clock.
// R4: Polarity bit inverts comparator output when set.
// R5: Three-bit field selects minus input; codes 11X reserved.
// R6: Software should avoid bandgap minus input when using comparator wake-up.
// R7: One bit selects plus input: ladder or port pin four.
// R8: Write-only enable drives comparator output onto port pin zero.
// R9: With wake enabled, any result level change wakes the device.
// R10: Two write-only bits select ladder high and low ranges.
// R11: Four-bit write-only ladder level, zero lowest, fifteen highest.
// R12: Four-bit field selects timer clock source; other codes reserved.
// R13: Two-bit field routes timer output to none, pin three or four.
// R14: Mode bit selects period mode or PWM mode.
// R15: Invert bit flips timer output polarity.
// R16: Comparator request flag set by hardware, held until software clears.
// R17: Two-bit edge select: both, rising or falling edges raise request.
// R18: Write-only fields hold last write, reset to zero, read undefined.
module cmp_tm2_ctrl
  import cmp_tm2_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire io_req_s io_req_in,
  output logic [7:0] io_rdata_out,
  input wire logic compare_raw_in,
  input wire logic fast_internal_rc_in,
  input wire logic slow_internal_rc_in,
  input wire logic port_a_pin_zero_in,
  input wire logic port_a_pin_four_in,
  input wire logic timer_wave_in,
  input wire logic sleeping_in,
  output analog_cfg_s analog_cfg_out,
  output timer_cfg_s timer_cfg_out,
  output logic timer_two_clock_out,
  output logic comparator_out,
  output logic port_a_pin_zero_out,
  output logic port_a_pin_zero_oe_out,
  output logic port_a_pin_three_out,
  output logic port_a_pin_three_oe_out,
  output logic port_a_pin_four_out,
  output logic port_a_pin_four_oe_out,
  output logic wake_out,
  output logic comparator_request_out
);

  typedef struct packed {
    logic [7:0] comparator_control;
    logic [7:0] timer_two_control;
    logic [7:0] comparator_selection;
    logic [1:0] edge_sel;
    logic request;
    logic sampled;
    logic last_out;
    logic wake;
    logic [7:0] rdata;
  } ctrl_state_s;

  ctrl_state_s state;
  ctrl_state_s next_state;

  logic cmp_level, cmp_rise, cmp_fall;
  logic fast_rise, slow_rise;
  logic pin0_rise, pin0_fall;
  logic pin4_rise, pin4_fall;
  logic timer_tick;
  logic cmp_result;
  logic out_now;
  logic out_rise, out_fall;
  logic timer_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for asynchronous sources

  edge_sync u_cmp (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in(compare_raw_in),
    .level_out(cmp_level),
    .rise_out(cmp_rise),
    .fall_out(cmp_fall)
  );

  edge_sync u_fast (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in(fast_internal_rc_in),
    .level_out(),
    .rise_out(fast_rise),
    .fall_out()
  );

  edge_sync u_slow (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in(slow_internal_rc_in),
    .level_out(),
    .rise_out(slow_rise),
    .fall_out()
  );

  edge_sync u_pin0 (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in(port_a_pin_zero_in),
    .level_out(),
    .rise_out(pin0_rise),
    .fall_out(pin0_fall)
  );

  edge_sync u_pin4 (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in(port_a_pin_four_in),
    .level_out(),
    .rise_out(pin4_rise),
    .fall_out(pin4_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator result path

  // Result bit: 1 when plus above minus, disabled comparator reads 0
  assign cmp_result = cmp_level & state.comparator_control[CC_ENABLE]; // R2

  // Raw or timer-clock-sampled, then optional inversion
  assign out_now = (state.comparator_control[CC_SAMPLE] ? state.sampled : cmp_result) // R3
                   ^ state.comparator_control[CC_INVERT]; // R4
  assign out_rise = out_now & ~state.last_out;
  assign out_fall = ~out_now & state.last_out;

  // Timer clock enable pulse per source
  always_comb begin
    case (state.timer_two_control[7:4]) // R12
      TCLK_SYSTEM: timer_tick = 1'b1;
      TCLK_FAST_RC: timer_tick = fast_rise;
      TCLK_SLOW_RC: timer_tick = slow_rise;
      TCLK_COMPARATOR: timer_tick = out_rise;
      TCLK_PIN0_RISE: timer_tick = pin0_rise;
      TCLK_PIN0_FALL: timer_tick = pin0_fall;
      TCLK_PIN4_RISE: timer_tick = pin4_rise;
      TCLK_PIN4_FALL: timer_tick = pin4_fall;
      default: timer_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and flags

  always_comb begin
    logic cmp_event;
    logic write_cc;
    logic clear_req;
    cmp_event = 1'b0;
    write_cc = io_req_in.write && io_req_in.addr == ADDR_COMPARATOR_CONTROL;
    clear_req = io_req_in.write && io_req_in.addr == ADDR_INT_REQUEST &&
                !io_req_in.wdata[REQ_BIT];
    next_state = state;
    next_state.last_out = out_now;
    if (timer_tick) begin
      next_state.sampled = cmp_result; // R3
    end
    if (write_cc) begin
      // Result bit is read-only
      next_state.comparator_control = {io_req_in.wdata[7], 1'b0, io_req_in.wdata[5:0]}; // R5 R7
    end
    if (io_req_in.write && io_req_in.addr == ADDR_TIMER_TWO_CONTROL) begin
      next_state.timer_two_control = io_req_in.wdata; // R12 R13 R14 R15
    end
    if (io_req_in.write && io_req_in.addr == ADDR_COMPARATOR_SELECTION) begin
      next_state.comparator_selection = io_req_in.wdata; // R18
    end
    if (io_req_in.write && io_req_in.addr == ADDR_INT_EDGE) begin
      next_state.edge_sel = io_req_in.wdata[EDGE_LSB +: 2];
    end
    case (state.edge_sel) // R17
      EDGE_BOTH: cmp_event = out_rise | out_fall;
      EDGE_RISE: cmp_event = out_rise;
      EDGE_FALL: cmp_event = out_fall;
      default: cmp_event = 1'b0;
    endcase
    // Set wins over a simultaneous clear
    if (cmp_event) begin
      next_state.request = 1'b1; // R16
    end else if (clear_req) begin
      next_state.request = 1'b0; // R16
    end
    // Wake on any change of the result bit; a disabled comparator holds it at 0
    next_state.wake = state.comparator_selection[CS_WAKE] & sleeping_in &
                      state.comparator_control[CC_ENABLE] &
                      (cmp_rise | cmp_fall); // R9
    next_state.rdata = RESET_BYTE;
    if (io_req_in.read) begin
      case (io_req_in.addr)
        ADDR_COMPARATOR_CONTROL: next_state.rdata = {state.comparator_control[7],
                                   cmp_result, state.comparator_control[5:0]}; // R2
        ADDR_TIMER_TWO_CONTROL: next_state.rdata = state.timer_two_control;
        ADDR_INT_REQUEST: next_state.rdata = {3'h0, state.request, 4'h0};
        default: next_state.rdata = RESET_BYTE; // R18
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs and pin routing

  assign timer_out = timer_wave_in ^ state.timer_two_control[0]; // R15

  always_comb begin
    analog_cfg_out.enable = state.comparator_control[CC_ENABLE];
    analog_cfg_out.minus_sel = state.comparator_control[3:1]; // R5
    analog_cfg_out.plus_sel = state.comparator_control[CC_PLUS]; // R7
    analog_cfg_out.high_range = state.comparator_selection[CS_HIGH_RANGE]; // R10
    analog_cfg_out.low_range = state.comparator_selection[CS_LOW_RANGE]; // R10
    analog_cfg_out.ladder_level = state.comparator_selection[3:0]; // R11
    timer_cfg_out.clock_sel = state.timer_two_control[7:4];
    timer_cfg_out.out_sel = state.timer_two_control[3:2];
    timer_cfg_out.pwm_mode = state.timer_two_control[1]; // R14
    timer_cfg_out.invert = state.timer_two_control[0];
  end

  assign timer_two_clock_out = timer_tick;
  assign comparator_out = state.last_out;
  assign port_a_pin_zero_out = state.last_out;
  assign port_a_pin_zero_oe_out = state.comparator_selection[CS_PIN_OUT]; // R8
  assign port_a_pin_three_out = timer_out;
  assign port_a_pin_three_oe_out = state.timer_two_control[3:2] == TOUT_PIN_THREE; // R13
  assign port_a_pin_four_out = timer_out;
  assign port_a_pin_four_oe_out = state.timer_two_control[3:2] == TOUT_PIN_FOUR; // R13
  assign wake_out = state.wake;
  assign comparator_request_out = state.request;
  assign io_rdata_out = state.rdata;

endmodule // cmp_tm2_ctrl

// file: dv/cmp_tm2_ctrl_sva.sv
/*
  Assertion checker for the comparator and timer-two control block.
  Assumes it is bound to cmp_tm2_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module cmp_tm2_ctrl_sva
  import cmp_tm2_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire io_req_s io_req_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic timer_wave_in,
  input wire logic sleeping_in,
  input wire analog_cfg_s analog_cfg_out,
  input wire timer_cfg_s timer_cfg_out,
  input wire logic timer_two_clock_out,
  input wire logic port_a_pin_zero_oe_out,
  input wire logic port_a_pin_three_out,
  input wire logic port_a_pin_three_oe_out,
  input wire logic port_a_pin_four_oe_out,
  input wire logic wake_out,
  input wire logic comparator_request_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  sequence s_wr(a);
    io_req_in.write && io_req_in.addr == a;
  endsequence
  sequence s_rd(a);
    io_req_in.read && !io_req_in.write && io_req_in.addr == a;
  endsequence

  a_cc_write: assert property (s_wr(ADDR_COMPARATOR_CONTROL) |=>
    {analog_cfg_out.enable, analog_cfg_out.minus_sel, analog_cfg_out.plus_sel} ==
    {$past(io_req_in.wdata[7]), $past(io_req_in.wdata[3:0])}) else $error("cc fields");
  a_sel_write: assert property (s_wr(ADDR_COMPARATOR_SELECTION) |=>
    {port_a_pin_zero_oe_out, analog_cfg_out.high_range, analog_cfg_out.low_range,
    analog_cfg_out.ladder_level} == {$past(io_req_in.wdata[7]), $past(io_req_in.wdata[5:0])})
    else $error("selection fields");
  a_tc_write: assert property (s_wr(ADDR_TIMER_TWO_CONTROL) |=>
    timer_cfg_out == $past(io_req_in.wdata)) else $error("timer cfg");
  a_tc_read: assert property (s_rd(ADDR_TIMER_TWO_CONTROL) |=>
    io_rdata_out == $past(timer_cfg_out)) else $error("timer read");
  a_tick_src: assert property (
    (timer_cfg_out.clock_sel == TCLK_SYSTEM) |-> timer_two_clock_out ##1
    (timer_cfg_out.clock_sel != TCLK_OFF || !timer_two_clock_out)) else $error("tick");
  a_tout_three: assert property ((timer_cfg_out.out_sel == TOUT_PIN_THREE) |->
    port_a_pin_three_oe_out && !port_a_pin_four_oe_out &&
    port_a_pin_three_out == (timer_wave_in ^ timer_cfg_out.invert)) else $error("pin three");
  a_tout_four: assert property (
    port_a_pin_four_oe_out == (timer_cfg_out.out_sel == TOUT_PIN_FOUR)) else $error("pin four");
  a_req_hold: assert property (comparator_request_out &&
    !(io_req_in.write && io_req_in.addr == ADDR_INT_REQUEST && !io_req_in.wdata[REQ_BIT]) |=>
    comparator_request_out) else $error("request dropped");
  a_wake_sleep: assert property (wake_out |-> $past(sleeping_in) ##1 !wake_out)
    else $error("wake");
endmodule // cmp_tm2_ctrl_sva

bind cmp_tm2_ctrl cmp_tm2_ctrl_sva u_sva (.clock_in(clock_in), .rstn_in(rstn_in),
  .io_req_in(io_req_in), .io_rdata_out(io_rdata_out), .timer_wave_in(timer_wave_in),
  .sleeping_in(sleeping_in), .analog_cfg_out(analog_cfg_out), .timer_cfg_out(timer_cfg_out),
  .timer_two_clock_out(timer_two_clock_out), .port_a_pin_zero_oe_out(port_a_pin_zero_oe_out),
  .port_a_pin_three_out(port_a_pin_three_out), .port_a_pin_three_oe_out(port_a_pin_three_oe_out),
  .port_a_pin_four_oe_out(port_a_pin_four_oe_out), .wake_out(wake_out),
  .comparator_request_out(comparator_request_out));

// file: dv/tb_comparator_and_timer2_control.sv
/*
  Self-checking bench for the comparator and timer-two control block.
  Assumes the IO port and one 50 MHz clock; RC and pin inputs toggled one at a time.
*/
`timescale 1ns/1ps
module tb_comparator_and_timer2_control;
  import cmp_tm2_pkg::*;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  io_req_s req = '0;
  logic raw = 1'b0;
  logic wave = 1'b0;
  logic sleep = 1'b0;
  logic [3:0] src = 4'h0;
  logic [7:0] rdata;
  analog_cfg_s acfg;
  timer_cfg_s tcfg;
  logic tick, cmp_o, p0, p0_oe, p3, p3_oe, p4, p4_oe, wake, irq;
  int miscompares = 0;
  int checks_done = 0;

  always #10 clock_in = ~clock_in;

  cmp_tm2_ctrl u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .io_req_in(req),
    .io_rdata_out(rdata), .compare_raw_in(raw), .fast_internal_rc_in(src[0]),
    .slow_internal_rc_in(src[1]), .port_a_pin_zero_in(src[2]), .port_a_pin_four_in(src[3]),
    .timer_wave_in(wave), .sleeping_in(sleep), .analog_cfg_out(acfg), .timer_cfg_out(tcfg),
    .timer_two_clock_out(tick), .comparator_out(cmp_o), .port_a_pin_zero_out(p0),
    .port_a_pin_zero_oe_out(p0_oe), .port_a_pin_three_out(p3), .port_a_pin_three_oe_out(p3_oe),
    .port_a_pin_four_out(p4), .port_a_pin_four_oe_out(p4_oe), .wake_out(wake),
    .comparator_request_out(irq));

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t ns: %s", $time, m);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    req <= '0;
    #1;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock_in);
    req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    req <= '0;
    #1 d = rdata;
  endtask

  task automatic settle(input logic v);
    @(posedge clock_in);
    raw <= v;
    repeat (6) @(posedge clock_in);
    #1;
  endtask

  task automatic count_wake(input logic v, output int n);
    n = 0;
    @(posedge clock_in);
    raw <= v;
    repeat (8) begin
      @(posedge clock_in);
      #1 n += int'(wake === 1'b1);
    end
  endtask

  task automatic count_tick(input logic [3:0] v, output int n);
    n = 0;
    @(posedge clock_in);
    src <= v;
    repeat (8) begin
      @(posedge clock_in);
      #1 n += int'(tick === 1'b1);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] d;
    chk(16'(acfg), 16'h0000, "analog config after reset");
    chk(16'(tcfg), 16'h0000, "timer config after reset");
    chk(16'({tick, cmp_o, p0_oe, p3_oe, p4_oe, wake, irq}), 16'h0000, "outputs after reset");
    rd(ADDR_TIMER_TWO_CONTROL, d);
    chk(16'(d), 16'h0000, "timer read after reset");
    $display("t_reset done");
  endtask

  task automatic t_timer;
    logic [3:0] cs [9] = '{TCLK_OFF, TCLK_SYSTEM, TCLK_FAST_RC, TCLK_SLOW_RC, TCLK_COMPARATOR,
      TCLK_PIN0_RISE, TCLK_PIN0_FALL, TCLK_PIN4_RISE, TCLK_PIN4_FALL};
    logic [7:0] d;
    logic [7:0] q;
    foreach (cs[i]) begin
      @(posedge clock_in);
      wave <= i[1];
      d = {cs[i], TOUT_PIN_THREE, i[1], i[0]};
      wr(ADDR_TIMER_TWO_CONTROL, d);
      rd(ADDR_TIMER_TWO_CONTROL, q);
      chk(16'({tcfg, q}), 16'({d, d}), "timer cfg");
      chk(16'({p3_oe, p4_oe, p3}), 16'({2'b10, i[1] ^ i[0]}), "pin three");
      if (i < 2) chk(16'(tick), 16'(i), "system tick");
    end
    wr(ADDR_TIMER_TWO_CONTROL, {TCLK_OFF, TOUT_PIN_FOUR, 2'b01});
    chk(16'({p3_oe, p4_oe, p4}), 16'({2'b01, ~wave}), "pin four");
    wr(ADDR_TIMER_TWO_CONTROL, 8'h00);
    chk(16'({p3_oe, p4_oe}), 16'h0000, "no timer output");
    $display("t_timer done");
  endtask

  task automatic t_comparator;
    logic [2:0] mc [6] = '{MINUS_PIN_THREE, MINUS_PIN_FOUR, MINUS_BANDGAP, MINUS_LADDER,
      MINUS_PIN_SIX, MINUS_PIN_SEVEN};
    logic [7:0] d;
    foreach (mc[i]) begin
      wr(ADDR_COMPARATOR_CONTROL, {4'h8, mc[i], i[0]});
      chk(16'({acfg.enable, acfg.minus_sel, acfg.plus_sel}), 16'({1'b1, mc[i], i[0]}),
        "input select");
    end
    wr(ADDR_TIMER_TWO_CONTROL, 8'h10);
    wr(ADDR_COMPARATOR_CONTROL, 8'hC0);
    settle(1'b0);
    rd(ADDR_COMPARATOR_CONTROL, d);
    chk(16'({d, cmp_o}), 16'h0100, "result low");
    settle(1'b1);
    rd(ADDR_COMPARATOR_CONTROL, d);
    chk(16'({d, cmp_o}), 16'h0181, "result high");
    wr(ADDR_COMPARATOR_CONTROL, 8'h90);
    settle(1'b1);
    chk(16'(cmp_o), 16'h0000, "inverted output");
    wr(ADDR_COMPARATOR_CONTROL, 8'hA0);
    settle(1'b0);
    wr(ADDR_TIMER_TWO_CONTROL, 8'h00);
    settle(1'b1);
    chk(16'(cmp_o), 16'h0000, "sampled holds without tick");
    wr(ADDR_TIMER_TWO_CONTROL, 8'h10);
    settle(1'b1);
    chk(16'(cmp_o), 16'h0001, "sampled follows tick");
    $display("t_comparator done");
  endtask

  task automatic t_select;
    logic [7:0] sv [2] = '{8'hE0, 8'h5F};
    logic [6:0] ev [2] = '{7'h60, 7'h1F};
    logic [7:0] d;
    int n;
    foreach (sv[i]) begin
      wr(ADDR_COMPARATOR_SELECTION, sv[i]);
      chk(16'({p0_oe, acfg.high_range, acfg.low_range, acfg.ladder_level}), 16'(ev[i]),
        "selection fields");
      chk(16'(p0 & p0_oe), 16'(ev[i][6]), "pin zero value");
    end
    rd(ADDR_COMPARATOR_SELECTION, d);
    chk(16'(d), 16'h0000, "selection read");
    @(posedge clock_in);
    sleep <= 1'b1;
    count_wake(1'b0, n);
    chk(16'(n), 16'h0001, "wake on change");
    wr(ADDR_COMPARATOR_SELECTION, 8'h00);
    count_wake(1'b1, n);
    chk(16'(n), 16'h0000, "no wake when off");
    @(posedge clock_in);
    sleep <= 1'b0;
    $display("t_select done");
  endtask

  task automatic t_request;
    logic [1:0] ec [3] = '{EDGE_BOTH, EDGE_RISE, EDGE_FALL};
    foreach (ec[i]) begin
      wr(ADDR_INT_EDGE, {ec[i], 6'h00});
      settle(1'b0);
      wr(ADDR_INT_REQUEST, 8'h00);
      settle(1'b1);
      chk(16'(irq), 16'(ec[i] != EDGE_FALL), "rise request");
      wr(ADDR_INT_REQUEST, 8'h00);
      settle(1'b0);
      chk(16'(irq), 16'(ec[i] != EDGE_RISE), "fall request");
    end
    $display("t_request done");
  endtask

  task automatic t_sources;
    logic [3:0] cc [6] = '{TCLK_FAST_RC, TCLK_SLOW_RC, TCLK_PIN0_RISE, TCLK_PIN0_FALL,
      TCLK_PIN4_RISE, TCLK_PIN4_FALL};
    logic [3:0] pin [6] = '{4'h1, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};
    logic rise_exp [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int n;
    foreach (cc[i]) begin
      wr(ADDR_TIMER_TWO_CONTROL, {cc[i], 4'h0});
      count_tick(pin[i], n);
      chk(16'(n), 16'(rise_exp[i]), "tick on source rise");
      count_tick(4'h0, n);
      chk(16'(n), 16'(!rise_exp[i]), "tick on source fall");
    end
    $display("t_sources done");
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock_in);
    rstn_in <= 1'b1;
    #1;
    t_reset();
    t_timer();
    t_comparator();
    t_select();
    t_request();
    t_sources();
    end_sim();
  end

  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule // tb_comparator_and_timer2_control
